// ==== shared/pin_state_pkg.sv ====
// Constants and types shared by the pin state control design
package pin_state_pkg;

  // Geometry
  localparam int PIN_COUNT  = 8;             // Controlled pins
  localparam int ADDR_WIDTH = 8;             // Register address width
  localparam int DATA_WIDTH = 8;             // Register data width
  localparam int FUNC_WIDTH = 4;             // Function code width

  // Register offsets
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;  // Level bit, release strobe
  localparam logic [7:0] STATUS_OFFSET  = 8'h01;  // Phase and reset status
  localparam logic [7:0] PININ_OFFSET   = 8'h02;  // Gated internal inputs
  localparam logic [7:0] PINCFG_OFFSET  = 8'h10;  // First pin function register
  localparam logic [7:0] PINCFG_LAST    = 8'h17;  // Last pin function register

  // Control register fields
  localparam int CTRL_HOLD_BIT    = 0;       // standby_pin_level_hold
  localparam int CTRL_RELEASE_BIT = 1;       // Release from return phase

  // Status register fields
  localparam int STAT_PHASE_LSB   = 0;       // Phase code, three bits
  localparam int STAT_KIND_LSB    = 3;       // Low-power kind, two bits
  localparam int STAT_DSTOP_BIT   = 5;       // Came back from deep stop
  localparam int STAT_RESET_BIT   = 6;       // Some reset source active

  // Reset values
  localparam logic             HOLD_RESET = 1'b0;        // Level bit after reset
  localparam logic [DATA_WIDTH-1:0] READ_ZERO = 8'h00;   // Unmapped read value

  // Requested power mode from the power controller
  typedef enum logic [2:0] {
    REQ_RUN     = 3'h0,
    REQ_TIMER   = 3'h1,
    REQ_RTC     = 3'h2,
    REQ_STOP    = 3'h3,
    REQ_DS_RTC  = 3'h4,
    REQ_DS_STOP = 3'h5
  } power_req_t;

  // Kind of low-power mode in force
  typedef enum logic [1:0] {
    KIND_TIMER = 2'h0,
    KIND_RTC   = 2'h1,
    KIND_STOP  = 2'h2
  } lp_kind_t;

  // Pin phase, Gray coded along reset, run, standby, deep, return
  typedef enum logic [2:0] {
    PH_RESET   = 3'b000,
    PH_RUN     = 3'b001,
    PH_STANDBY = 3'b011,
    PH_DEEP    = 3'b010,
    PH_RETURN  = 3'b110
  } phase_t;

  // Pin function selection
  typedef enum logic [3:0] {
    FN_GPIO     = 4'h0,
    FN_RESOURCE = 4'h1,
    FN_EXTINT   = 4'h2,
    FN_NMI      = 4'h3,
    FN_WAKE     = 4'h4,
    FN_CEC      = 4'h5,
    FN_ANA_IN   = 4'h6,
    FN_ANA_OUT  = 4'h7,
    FN_SUBCLK   = 4'h8,
    FN_SUBOSC   = 4'h9,
    FN_MODE_IN  = 4'hA
  } pin_func_t;

endpackage

// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;  // First stage, read only by second

  // Plain double flop, no reset needed for a data path
  always_ff @(posedge clk_sys) begin
    stage1_reg <= asyncIn;
    syncOut    <= stage1_reg;
  end

endmodule // pin_sync

// ==== rtl/pin_state_decide.sv ====
// Per-pin decision of output and input behaviour for the current phase
`timescale 1ns/1ns
module pin_state_decide (
  input  wire logic       [3:0] func,
  input  pin_state_pkg::phase_t phase,
  input  pin_state_pkg::lp_kind_t kind,
  input  wire logic             holdBit,
  input  wire logic             resetActive,
  input  wire logic             fromDeepStop,
  output logic                  latchOut,
  output logic                  floatOut,
  output logic                  gateIn,
  output logic                  wakeEn,
  output logic                  analogEn
);
  import pin_state_pkg::*;

  logic lowPower;  // Standby or deep standby phase
  logic isStop;    // Oscillator stopped in this mode

  // Decision table
  always_comb begin
    lowPower = (phase == PH_STANDBY) || (phase == PH_DEEP);
    isStop   = (kind == KIND_STOP);
    latchOut = 1'b0;
    floatOut = 1'b0;
    gateIn   = 1'b0;
    wakeEn   = 1'b0;
    analogEn = 1'b0;
    if (func == FN_CEC) begin
    end else if (func == FN_MODE_IN) begin
      floatOut = 1'b1;
    end else if (func == FN_ANA_IN) begin
      floatOut = 1'b1;
      gateIn   = 1'b1;
      analogEn = 1'b1;
    end else if (resetActive || phase == PH_RESET) begin
      // Selections ignored, input left enabled
      floatOut = 1'b1;
    end else if (func == FN_SUBOSC && lowPower && isStop) begin
      floatOut = 1'b1;
      gateIn   = 1'b1;
    end else if (func == FN_SUBCLK && lowPower) begin
      if (holdBit) begin
        floatOut = 1'b1;
        gateIn   = isStop;
      end else if (isStop) begin
        latchOut = 1'b1;
        gateIn   = 1'b1;
      end
    end else if (func == FN_ANA_OUT && phase == PH_STANDBY) begin
      if (kind != KIND_TIMER) begin
        floatOut = holdBit;
        gateIn   = 1'b1;
      end
    end else if (func == FN_WAKE && phase == PH_DEEP) begin
      wakeEn   = 1'b1;
      gateIn   = 1'b1;
      floatOut = holdBit;
      latchOut = !holdBit;
    end else if ((func == FN_NMI || func == FN_EXTINT) && phase == PH_STANDBY && holdBit) begin
    end else if (lowPower) begin
      gateIn   = 1'b1;
      floatOut = holdBit;
      latchOut = !holdBit;
    end else if (phase == PH_RETURN && func == FN_SUBCLK && fromDeepStop) begin
      // Back to port function, live
    end
  end

endmodule // pin_state_decide

// ==== rtl/pin_state_ctrl.sv ====
// Pin state control across reset and low-power modes
`timescale 1ns/1ns
module pin_state_ctrl
  import pin_state_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 porActive,
  input  wire logic                 lvdActive,
  input  wire logic                 external_reset_input_n,
  input  pin_state_pkg::power_req_t powerReq,
  input  wire logic                 wakeReturn,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [7:0]           regRdata,
  input  wire logic [7:0]           portOut,
  input  wire logic [7:0]           portOeN,
  input  wire logic [7:0]           pinIn,
  output logic      [7:0]           padOut,
  output logic      [7:0]           padOeN,
  output logic      [7:0]           internalIn,
  output logic      [7:0]           wakeIn,
  output logic      [7:0]           analogEn
);
  import pin_state_pkg::*;

  // Synchronised pin levels
  logic [PIN_COUNT-1:0] pinSync;       // Pin levels on the system clock
  logic                 extResetSync;  // External reset, synchronised
  logic                 resetActive;   // Any reset source active

  // Control state
  phase_t               phase_reg, phase_next;       // Pin phase
  lp_kind_t             kind_reg, kind_next;         // Low-power kind
  logic                 fromStop_reg, fromStop_next; // Came from deep stop
  logic                 hold_reg, hold_next;         // standby_pin_level_hold
  logic [3:0]           cfg_reg [PIN_COUNT];         // Function per pin
  logic [3:0]           cfg_next [PIN_COUNT];
  logic [7:0]           rdata_next;                  // Read data next
  logic                 releaseReq;                  // Release strobe

  // Per-pin decisions and held values
  logic [PIN_COUNT-1:0] latchV, floatV, gateV, wakeV, anaV;
  logic [PIN_COUNT-1:0] heldOut_reg, heldOut_next;   // Last driven level
  logic [PIN_COUNT-1:0] heldOeN_reg, heldOeN_next;   // Last drive enable
  logic [PIN_COUNT-1:0] padOut_next, padOeN_next;
  logic [PIN_COUNT-1:0] intIn_next, wake_next, ana_next;

  // True for an address inside the pin function block
  function automatic logic isCfgAddr(input logic [7:0] a);
    return (a >= PINCFG_OFFSET) && (a <= PINCFG_LAST);
  endfunction

  // Pin input synchroniser
  pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
    .clk_sys (clk_sys),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  // Reset pin synchroniser
  pin_sync #(.WIDTH(1)) u_rst_sync (
    .clk_sys (clk_sys),
    .asyncIn (external_reset_input_n),
    .syncOut (extResetSync)
  );

  assign resetActive = porActive || lvdActive || !extResetSync;

  // One decision cell per pin
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    pin_state_decide u_decide (
      .func         (cfg_reg[i]),
      .phase        (phase_reg),
      .kind         (kind_reg),
      .holdBit      (hold_reg),
      .resetActive  (resetActive),
      .fromDeepStop (fromStop_reg),
      .latchOut     (latchV[i]),
      .floatOut     (floatV[i]),
      .gateIn       (gateV[i]),
      .wakeEn       (wakeV[i]),
      .analogEn     (anaV[i])
    );
  end

  assign releaseReq = regWrite && (regAddr == CTRL_OFFSET) && regWdata[CTRL_RELEASE_BIT];

  // Phase sequencing and register writes
  always_comb begin
    phase_next    = phase_reg;
    kind_next     = kind_reg;
    fromStop_next = fromStop_reg;
    hold_next     = hold_reg;
    for (int i = 0; i < PIN_COUNT; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (regWrite && regAddr == CTRL_OFFSET) begin
      hold_next = regWdata[CTRL_HOLD_BIT];
    end
    if (regWrite && isCfgAddr(regAddr)) begin
      cfg_next[regAddr[2:0]] = regWdata[3:0];
    end
    case (phase_reg)
      PH_RESET: begin
        if (!resetActive) begin
          phase_next = PH_RUN;
        end
      end
      PH_RUN: begin
        case (powerReq)
          REQ_TIMER:   begin phase_next = PH_STANDBY; kind_next = KIND_TIMER; end
          REQ_RTC:     begin phase_next = PH_STANDBY; kind_next = KIND_RTC;   end
          REQ_STOP:    begin phase_next = PH_STANDBY; kind_next = KIND_STOP;  end
          REQ_DS_RTC:  begin phase_next = PH_DEEP;    kind_next = KIND_RTC;   end
          REQ_DS_STOP: begin phase_next = PH_DEEP;    kind_next = KIND_STOP;  end
          default:     begin phase_next = PH_RUN; end
        endcase
      end
      PH_STANDBY: begin
        if (powerReq == REQ_RUN) begin
          phase_next = PH_RUN;
        end
      end
      PH_DEEP: begin
        if (wakeReturn) begin
          phase_next    = PH_RETURN;
          fromStop_next = (kind_reg == KIND_STOP);
          if (kind_reg == KIND_STOP) begin
            // Sub clock selections fall back to port function
            for (int i = 0; i < PIN_COUNT; i++) begin
              if (cfg_reg[i] == FN_SUBCLK) begin
                cfg_next[i] = FN_GPIO;
              end
            end
          end
        end
      end
      PH_RETURN: begin
        if (releaseReq) begin
          phase_next    = PH_RUN;
          fromStop_next = 1'b0;
        end
      end
      default: begin
        phase_next = PH_RESET;
      end
    endcase
    if (resetActive) begin
      phase_next = PH_RESET;
    end
  end

  // Phase and configuration registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase_reg    <= PH_RESET;
      kind_reg     <= KIND_TIMER;
      fromStop_reg <= 1'b0;
      hold_reg     <= HOLD_RESET;
      for (int i = 0; i < PIN_COUNT; i++) begin
        cfg_reg[i] <= FN_GPIO;
      end
    end else begin
      phase_reg    <= phase_next;
      kind_reg     <= kind_next;
      fromStop_reg <= fromStop_next;
      hold_reg     <= hold_next;
      for (int i = 0; i < PIN_COUNT; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // Pad drive and gated inputs
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      // Held copy tracks the port while not latched
      heldOut_next[i] = latchV[i] ? heldOut_reg[i] : portOut[i];
      heldOeN_next[i] = latchV[i] ? heldOeN_reg[i] : portOeN[i];
      padOut_next[i]  = latchV[i] ? heldOut_reg[i] : portOut[i];
      padOeN_next[i]  = floatV[i] || (latchV[i] ? heldOeN_reg[i] : portOeN[i]);
      intIn_next[i]   = gateV[i] ? 1'b0 : pinSync[i];
      wake_next[i]    = wakeV[i] ? pinSync[i] : 1'b0;
      ana_next[i]     = anaV[i];
    end
  end

  // Pad registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      heldOut_reg <= 8'h00;
      heldOeN_reg <= 8'hFF;
      padOut      <= 8'h00;
      padOeN      <= 8'hFF;
      internalIn  <= 8'h00;
      wakeIn      <= 8'h00;
      analogEn    <= 8'h00;
    end else begin
      heldOut_reg <= heldOut_next;
      heldOeN_reg <= heldOeN_next;
      padOut      <= padOut_next;
      padOeN      <= padOeN_next;
      internalIn  <= intIn_next;
      wakeIn      <= wake_next;
      analogEn    <= ana_next;
    end
  end

  // Register read mux
  always_comb begin
    rdata_next = READ_ZERO;
    if (regRead) begin
      if (regAddr == CTRL_OFFSET) begin
        rdata_next[CTRL_HOLD_BIT] = hold_reg;
      end else if (regAddr == STATUS_OFFSET) begin
        rdata_next[STAT_PHASE_LSB +: 3] = phase_reg;
        rdata_next[STAT_KIND_LSB +: 2]  = kind_reg;
        rdata_next[STAT_DSTOP_BIT]      = fromStop_reg;
        rdata_next[STAT_RESET_BIT]      = resetActive;
      end else if (regAddr == PININ_OFFSET) begin
        rdata_next = internalIn;
      end else if (isCfgAddr(regAddr)) begin
        rdata_next[3:0] = cfg_reg[regAddr[2:0]];
      end
    end
  end

  // Read data register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdata <= READ_ZERO;
    end else begin
      regRdata <= rdata_next;
    end
  end

  // Checks on every pin, so each function is seen wherever it is placed
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_chk
    a_cec_live: assert property ((cfg_reg[p] == FN_CEC) |=>
      padOut[p] == $past(portOut[p]) && padOeN[p] == $past(portOeN[p]))
      else $error("CEC pin not passed through");
    a_gpio_latch: assert property ((phase_reg == PH_STANDBY && !hold_reg &&
      cfg_reg[p] == FN_GPIO && !resetActive) |=>
      !internalIn[p] && padOut[p] == $past(heldOut_reg[p]))
      else $error("Standby GPIO not latched and gated");
    a_wake_float: assert property ((phase_reg == PH_DEEP && hold_reg &&
      cfg_reg[p] == FN_WAKE && !resetActive) |=>
      padOeN[p] && wakeIn[p] == $past(pinSync[p]))
      else $error("Wake pin not floating wake input");
    a_mode_input: assert property ((cfg_reg[p] == FN_MODE_IN) |=>
      internalIn[p] == $past(pinSync[p]) && padOeN[p])
      else $error("Mode input path not enabled");
    a_analog_in: assert property ((cfg_reg[p] == FN_ANA_IN) |=>
      padOeN[p] && !internalIn[p] && analogEn[p])
      else $error("Analog input pin misdriven");
    a_subclk_revert: assert property ((phase_reg == PH_DEEP && kind_reg == KIND_STOP &&
      wakeReturn && !resetActive && cfg_reg[p] == FN_SUBCLK) |=> cfg_reg[p] == FN_GPIO
      && phase_reg == PH_RETURN)
      else $error("Sub clock selection not reverted");
    a_osc_stop: assert property ((phase_reg == PH_STANDBY && kind_reg == KIND_STOP &&
      cfg_reg[p] == FN_SUBOSC && !resetActive) |=> padOeN[p] && !internalIn[p])
      else $error("Oscillator pin not floated in stop");
    a_anaout_port: assert property ((phase_reg == PH_STANDBY && kind_reg != KIND_TIMER &&
      !hold_reg && cfg_reg[p] == FN_ANA_OUT && !resetActive) |=>
      padOut[p] == $past(portOut[p]) && !internalIn[p])
      else $error("Analog output not back to port");
    a_anaout_float: assert property ((phase_reg == PH_STANDBY && kind_reg != KIND_TIMER &&
      hold_reg && cfg_reg[p] == FN_ANA_OUT && !resetActive) |=> padOeN[p] && !internalIn[p])
      else $error("Analog output not floated");
    a_reset_float: assert property ((resetActive && cfg_reg[p] != FN_CEC) |=>
      padOeN[p] && phase_reg == PH_RESET)
      else $error("Pin driven during reset");
    a_nmi_keep: assert property ((phase_reg == PH_STANDBY && hold_reg &&
      cfg_reg[p] == FN_NMI && !resetActive) |=> padOut[p] == $past(portOut[p])
      && padOeN[p] == $past(portOeN[p]))
      else $error("Interrupt pin not kept live");
  end

endmodule // pin_state_ctrl

// ==== verif/board_model.sv ====
// Board circuitry around the controlled pins
`timescale 1ns/1ns
module board_model (
  input  wire logic [7:0] padOut,     // Level driven by the device
  input  wire logic [7:0] padOeN,     // Device drive enable, low drives
  input  wire logic [7:0] boardLevel, // Level the board puts on a floating pin
  output logic      [7:0] pinLevel    // Resulting wire level
);
  // Wire level per pin: the device wins while it drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinLevel[i] = padOeN[i] ? boardLevel[i] : padOut[i];
    end
  end
endmodule // board_model

// ==== verif/test_pin_state_low_power_control.sv ====
// Self-checking bench for the pin state control block
`timescale 1ns/1ns
module test_pin_state_low_power_control;
  import pin_state_pkg::*;
  logic       clk_sys = 1'b0;          // System clock
  logic       reset_n;                 // Synchronous reset
  logic       porActive;               // Power-on reset source
  logic       lvdActive;               // Low-voltage source
  logic       external_reset_input_n;  // External reset pin
  power_req_t powerReq;                // Requested mode
  logic       wakeReturn;              // Deep standby return
  logic [7:0] regAddr;                 // Register address
  logic [7:0] regWdata;                // Register write data
  logic       regWrite;                // Write strobe
  logic       regRead;                 // Read strobe
  logic [7:0] regRdata;                // Read data
  logic [7:0] portOut;                 // Port function level
  logic [7:0] portOeN;                 // Port function enable
  logic [7:0] pinLevel;                // Wire levels
  logic [7:0] padOut;                  // Pad levels
  logic [7:0] padOeN;                  // Pad enables
  logic [7:0] internalIn;              // Gated inputs
  logic [7:0] wakeIn;                  // Wake paths
  logic [7:0] analogEn;                // Analog paths
  logic [7:0] boardLevel;              // Board level on floating pins
  logic [7:0] savedOut;                // Port level at low-power entry
  logic [7:0] savedOeN;                // Port enable at low-power entry
  logic [3:0] fnTab [8];               // Model of pin functions
  int         n_errors;                // Mismatches
  int         num_checks;              // Comparisons
  int         seed = 4;                // Random seed

  // Clock, 40 ns period
  always #20 clk_sys = ~clk_sys;

  // Design under test
  pin_state_ctrl i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .porActive(porActive),
    .lvdActive(lvdActive), .external_reset_input_n(external_reset_input_n),
    .powerReq(powerReq), .wakeReturn(wakeReturn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .portOut(portOut),
    .portOeN(portOeN), .pinIn(pinLevel), .padOut(padOut), .padOeN(padOeN),
    .internalIn(internalIn), .wakeIn(wakeIn), .analogEn(analogEn));

  // Board on the far side of the pads
  board_model i_board (.padOut(padOut), .padOeN(padOeN), .boardLevel(boardLevel),
    .pinLevel(pinLevel));

  // Masked comparison with count
  task chk(string name, logic [7:0] expv, logic [7:0] got, logic [7:0] mask);
    num_checks++;
    if ((got & mask) !== (expv & mask)) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, expv & mask, got & mask);
    end
  endtask

  // One write cycle
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  // One read cycle, data taken in the following cycle, then idle zero
  task rd_chk(string name, logic [7:0] a, logic [7:0] expv, logic [7:0] mask);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(name, expv, regRdata, mask);
    @(posedge clk_sys);
    #1;
    chk("rdata idle", 8'h00, regRdata, 8'hFF);
  endtask

  // Wait whole cycles
  task cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Reference model of the pads; ph 0 run, 1 standby, 2 deep, 3 reset
  task model_chk(int ph, int kind, bit hold);
    logic [7:0] eOe, eOut, eIn, eAn, eWk, mOe, mOut, mIn, mWk;
    int f;
    bit live, lat, flt, gate;
    {eOe, eOut, eIn, eAn, eWk, mOe, mOut, mIn, mWk} = '0;
    #1;
    for (int i = 0; i < 8; i++) begin
      f = fnTab[i];
      {live, lat, flt, gate} = 4'h0;
      eAn[i] = (f == FN_ANA_IN);
      if (f == FN_CEC) live = 1;
      else if (f == FN_MODE_IN) begin
        mIn[i] = 1'b1;
        eIn[i] = boardLevel[i];
      end
      else if (f == FN_ANA_IN) {flt, gate} = 2'b11;
      else if (ph == 3) flt = 1;
      else if (ph == 0) live = 1;
      else if (f == FN_GPIO || (f == FN_NMI && !(hold && ph == 1))) begin
        flt = hold;
        lat = !hold;
        gate = 1;
      end
      else if (f == FN_NMI) live = 1;
      else if (f == FN_ANA_OUT && kind == 0 && ph == 1) live = 1;
      else if (f == FN_ANA_OUT) {flt, gate, live} = {hold, 1'b1, !hold && ph == 1};
      else if (f == FN_SUBOSC && kind == 2 && ph == 1) {flt, gate} = 2'b11;
      else if (f == FN_SUBCLK) begin
        {flt, gate} = {hold, kind == 2};
        {lat, live} = {!hold && kind == 2, !hold && kind != 2};
      end
      else if (f == FN_WAKE && ph == 2) begin
        {flt, gate, lat} = {hold, !hold, !hold};
        mWk[i] = 1'b1;
        eWk[i] = boardLevel[i];
      end
      if (live) {mOe[i], eOe[i], mOut[i], eOut[i]} = {1'b1, portOeN[i], !portOeN[i], portOut[i]};
      if (lat) {mOe[i], eOe[i], mOut[i], eOut[i]} = {1'b1, savedOeN[i], !savedOeN[i], savedOut[i]};
      if (flt) {mOe[i], eOe[i]} = 2'b11;
      if (gate) {mIn[i], eIn[i]} = 2'b10;
    end
    chk("padOeN", eOe, padOeN, mOe);
    chk("padOut", eOut, padOut, mOut);
    chk("internalIn", eIn, internalIn, mIn);
    chk("analogEn", eAn, analogEn, 8'hFF);
    chk("wakeIn", eWk, wakeIn, mWk);
  endtask

  // Verdict and end of run
  task complete_run;
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    {reset_n, porActive, lvdActive, wakeReturn, regWrite, regRead} = '0;
    external_reset_input_n = 1'b1;
    powerReq = REQ_RUN;
    {regAddr, regWdata, portOut} = '0;
    portOeN = 8'hFF;
    boardLevel = $random(seed);
    fnTab = '{FN_CEC, FN_GPIO, FN_WAKE, FN_MODE_IN, FN_ANA_IN, FN_ANA_OUT, FN_SUBOSC, FN_NMI};
    cyc(10);
    #1;
    chk("reset padOeN", 8'hFF, padOeN, 8'hFF);
    chk("reset padOut", 8'h00, padOut, 8'hFF);
    reset_n <= 1'b1;
    cyc(5);
    rd_chk("status", STATUS_OFFSET, 8'h01, 8'h47);
    rd_chk("unmapped", 8'h20, READ_ZERO, 8'hFF);
    for (int i = 0; i < 8; i++) wr(PINCFG_OFFSET + 8'(i), {4'h0, fnTab[i]});
    for (int i = 0; i < 8; i++) rd_chk("pincfg", PINCFG_OFFSET + 8'(i), {4'h0, fnTab[i]}, 8'h0F);
    portOeN <= 8'h1C;
    // Standby kinds under both level bit settings
    for (int h = 0; h < 2; h++) begin
      wr(CTRL_OFFSET, 8'(h));
      rd_chk("ctrl", CTRL_OFFSET, 8'(h), 8'h03);
      for (int k = 0; k < 3; k++) begin
        portOut <= $random(seed);
        boardLevel <= $random(seed);
        cyc(4);
        model_chk(0, k, h[0]);
        savedOut = portOut;
        savedOeN = portOeN;
        powerReq <= power_req_t'(3'(k + 1));
        cyc(4);
        portOut <= ~savedOut;
        cyc(4);
        model_chk(1, k, h[0]);
        rd_chk("status", STATUS_OFFSET, {3'b000, 2'(k), 3'b011}, 8'h1F);
        powerReq <= REQ_RUN;
        cyc(4);
      end
    end
    // Deep standby and return, sub clock selection on pin 6
    wr(PINCFG_OFFSET + 8'h06, {4'h0, FN_SUBCLK});
    fnTab[6] = FN_SUBCLK;
    for (int j = 0; j < 4; j++) begin
      wr(CTRL_OFFSET, 8'(j % 2));
      portOut <= $random(seed);
      boardLevel <= $random(seed);
      cyc(4);
      savedOut = portOut;
      savedOeN = portOeN;
      powerReq <= (j > 1) ? REQ_DS_STOP : REQ_DS_RTC;
      cyc(4);
      portOut <= ~savedOut;
      cyc(4);
      model_chk(2, (j > 1) ? 2 : 1, j[0]);
      rd_chk("status", STATUS_OFFSET, 8'h02, 8'h07);
      powerReq <= REQ_RUN;
      wakeReturn <= 1'b1;
      cyc(1);
      wakeReturn <= 1'b0;
      cyc(3);
      rd_chk("status", STATUS_OFFSET, {2'b00, j[1], 5'b00110}, 8'h27);
      rd_chk("pincfg", PINCFG_OFFSET + 8'h06, (j > 1) ? 8'h00 : 8'h08, 8'h0F);
      wr(CTRL_OFFSET, 8'(2 + j % 2));
      cyc(3);
      rd_chk("status", STATUS_OFFSET, 8'h01, 8'h07);
      wr(PINCFG_OFFSET + 8'h06, {4'h0, FN_SUBCLK});
    end
    // Each reset source in turn
    for (int s = 0; s < 3; s++) begin
      portOut <= $random(seed);
      porActive <= (s == 0);
      lvdActive <= (s == 1);
      external_reset_input_n <= (s != 2);
      cyc(6);
      model_chk(3, 0, 1'b0);
      rd_chk("status", STATUS_OFFSET, 8'h40, 8'h47);
      {porActive, lvdActive} <= 2'b00;
      external_reset_input_n <= 1'b1;
      cyc(6);
      model_chk(0, 0, 1'b0);
      rd_chk("pincfg", PINCFG_OFFSET + 8'h07, {4'h0, fnTab[7]}, 8'h0F);
    end
    complete_run();
  end
endmodule // test_pin_state_low_power_control
